// ---- rtl/usart_consts.svh ----
// constants of the usart baud generator and receive control block
// assumes: included by bare name from the package, the checker and the bench
//
// Behaviour
// - free-running 8-bit timer period from divisor
// - async low speed: fosc/(64(x+1))
// - async high speed: fosc/(16(x+1))
// - sync: fosc/(4(x+1)), no high-speed variant
// - high-speed select ignored in sync mode
// - in sync mode, divisor rates only as master
// - divisor is unsigned 8 bits, 0..255
// - divisor write clears the generator timer
// - rx pin majority-voted over three samples
// - single receive, sync master only: one word, then cleared
// - continuous receive until cleared, overrides single
// - overrun read-only, cleared with continuous enable
// - ninth bit read-only, no hardware parity
// - sync mode bit selects sync or async
// - generator runs x4, x16 or x64 bit rate
// - clock source set: master, clear: slave
`ifndef USART_CONSTS_SVH
`define USART_CONSTS_SVH

// ----------------------------------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------------------------------
`define IDX_RCS      8'h18
`define IDX_TCS      8'h98
`define IDX_DIV      8'h99
`define IDX_RBUF     8'h1a
`define ADDR_HI_W    22

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RCS_ON       7
`define RCS_NINE     6
`define RCS_SINGLE   5
`define RCS_CONT     4
`define RCS_FRAMING_ERROR_FLAG     2
`define RCS_OVERRUN_ERROR_FLAG     1
`define RCS_RECEIVED_NINTH_BIT     0
`define TCS_CLOCK_SOURCE_SELECT     7
`define TCS_SYNC     4
`define TCS_HIGH_SPEED_SELECT     2
`define TCS_TRMT     1

// ----------------------------------------------------------------
// reset values and masks
// ----------------------------------------------------------------
`define TCS_RESET    8'h02
`define TCS_WMASK    8'hf5
`define DIV_RESET    8'h00

// ----------------------------------------------------------------
// generator ticks per bit and word lengths
// ----------------------------------------------------------------
`define TICKS_ALOW   7'h40
`define TICKS_AHIGH  7'h10
`define TICKS_SYNC   7'h04
`define BITS_EIGHT   4'h8
`define BITS_NINE    4'h9

`endif

// ---- rtl/usart_pkg.sv ----
// types of the usart baud generator and receive control block
// assumes: constants header sits beside it
`include "usart_consts.svh"

package usart_pkg;

    typedef enum logic [1:0] {
        RX_IDLE,
        RX_START,
        RX_DATA,
        RX_STOP
    } rx_state_e;

    typedef struct packed {
        logic             serial_port_on;
        logic             nine_bit_receive;
        logic             single_rx_enable;
        logic             continuous_rx_enable;
        logic             framing_error_flag;
        logic             overrun_error_flag;
        logic             received_ninth_bit;
        logic [7:0]       tcs;
        logic [7:0]       baud_divisor;
        logic [7:0]       brg_cnt;
        logic [6:0]       phase;
        rx_state_e        rx_state;
        logic [3:0]       bit_cnt;
        logic [8:0]       shift;
        logic [7:0]       receive_buffer;
        logic             buf_full;
        logic             ext_clk_prev;
        logic             clk_out;
        logic             clk_oe;
        logic             ap_valid;
        logic             ap_write;
        logic [7:0]       ap_index;
        logic [31:0]      hrdata;
        logic             hreadyout;
    } usart_state_s;

    typedef struct packed {
        logic [2:0] hist;
        logic       vote;
    } vote_state_s;

endpackage

// ---- rtl/sample_if.sv ----
// carrier between the receive control logic and the majority sampler
// assumes: both ends on the same clock
`timescale 1ns/1ps
`default_nettype none

interface sample_if;
    logic stb;
    logic pin;
    logic vote;

    modport ctrl (output stb, output pin, input vote);
    modport smp  (input stb, input pin, output vote);
endinterface

`default_nettype wire

// ---- rtl/majority_sampler.sv ----
// three-sample majority voter for the receive data pin
// assumes: pin already synchronous to clk, strobe from the controller
`timescale 1ns/1ps
`default_nettype none

module majority_sampler (
    input  wire logic clk,
    input  wire logic rst,
    sample_if.smp     s
);
    import usart_pkg::*;

    vote_state_s cur_ff;
    vote_state_s nxt_st;

    always_comb begin
        nxt_st = cur_ff;
        if (s.stb) begin
            nxt_st.hist = {cur_ff.hist[1:0], s.pin};
            nxt_st.vote = (cur_ff.hist[1] & cur_ff.hist[0]) |
                          (cur_ff.hist[1] & s.pin) | (cur_ff.hist[0] & s.pin);
        end
    end

    // idle line is high, so history starts high
    always_ff @(posedge clk) begin
        if (rst) begin
            cur_ff <= '{hist: 3'h7, vote: 1'b1};
        end else begin
            cur_ff <= nxt_st;
        end
    end

    assign s.vote = cur_ff.vote;

endmodule

`default_nettype wire

// ---- rtl/usart_rx_baud.sv ----
// baud generator and receive control/status with an ahb-lite register slave
// assumes: single ahb-lite master, word transfers, pins synchronous to clk
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/1ps
`default_nettype none

module usart_rx_baud (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        rx_data_pin,
    input  wire logic        tx_clock_pin_in,
    output logic             tx_clock_pin_out,
    output logic             tx_clock_pin_oe
);
    import usart_pkg::*;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // divide ratios
    function automatic logic [6:0] bit_ticks(input logic sync_m, input logic high_speed_select);
        if (sync_m) begin
            bit_ticks = `TICKS_SYNC;
        end else if (high_speed_select) begin
            bit_ticks = `TICKS_AHIGH;
        end else begin
            bit_ticks = `TICKS_ALOW;
        end
    endfunction

    function automatic logic is_mapped(input logic [7:0] idx);
        is_mapped = (idx == `IDX_RCS) || (idx == `IDX_TCS) ||
                    (idx == `IDX_DIV) || (idx == `IDX_RBUF);
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    usart_state_s cur_ff;
    usart_state_s nxt_st;

    sample_if smp_bus ();

    majority_sampler u_sampler (
        .clk (clk),
        .rst (rst),
        .s   (smp_bus.smp)
    );

    logic       sync_m;
    logic       master;
    logic       tick;
    logic [6:0] per;
    logic [6:0] win;
    logic       decide;
    logic       ext_fall;
    logic [3:0] nbits;
    logic [7:0] rd_idx;
    logic       rd_take;
    logic [7:0] rcs_view;
    logic       rx_done;
    logic       rx_framing_error_flag;
    logic       want_sync;

    assign sync_m   = cur_ff.tcs[`TCS_SYNC];
    assign master   = sync_m & cur_ff.tcs[`TCS_CLOCK_SOURCE_SELECT];
    assign tick     = (cur_ff.brg_cnt == 8'h00);
    assign per      = bit_ticks(sync_m, cur_ff.tcs[`TCS_HIGH_SPEED_SELECT]);
    assign win      = (per >> 1) - 7'h2;
    assign nbits    = cur_ff.nine_bit_receive ? `BITS_NINE : `BITS_EIGHT;
    assign ext_fall = cur_ff.ext_clk_prev & ~tx_clock_pin_in;
    // slave bits follow the external clock
    assign decide   = (sync_m & ~master) ? ext_fall : (tick && cur_ff.phase == per - 7'h1);
    assign rd_idx   = haddr[9:2];
    assign rd_take  = hsel & hready & htrans[1] & (haddr[31:10] == {`ADDR_HI_W{1'b0}});

    assign want_sync = cur_ff.serial_port_on & sync_m &
                       (master ? (cur_ff.continuous_rx_enable | cur_ff.single_rx_enable)
                               : cur_ff.continuous_rx_enable);

    // three strobes around mid-bit, every cycle in slave mode
    assign smp_bus.pin = rx_data_pin;
    assign smp_bus.stb = (sync_m & ~master) ? 1'b1 :
                         (tick && cur_ff.phase >= win && cur_ff.phase <= win + 7'h2);

    assign rcs_view = {cur_ff.serial_port_on, cur_ff.nine_bit_receive,
                       cur_ff.single_rx_enable, cur_ff.continuous_rx_enable, 1'b0,
                       cur_ff.framing_error_flag, cur_ff.overrun_error_flag,
                       cur_ff.received_ninth_bit};

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        nxt_st          = cur_ff;
        rx_done         = 1'b0;
        rx_framing_error_flag         = 1'b0;
        nxt_st.ext_clk_prev = tx_clock_pin_in;

        // free-running down counter, reload with divisor
        if (tick) begin
            nxt_st.brg_cnt = cur_ff.baud_divisor;
        end else begin
            nxt_st.brg_cnt = cur_ff.brg_cnt - 8'h01;
        end

        // bit phase advances on generator ticks
        if (tick) begin
            nxt_st.phase = (cur_ff.phase == per - 7'h1) ? 7'h00 : cur_ff.phase + 7'h01;
        end

        // receive sequencer
        case (cur_ff.rx_state)
            RX_IDLE: begin
                nxt_st.phase = 7'h00;
                if (!sync_m && cur_ff.serial_port_on && cur_ff.continuous_rx_enable &&
                    !cur_ff.overrun_error_flag && !rx_data_pin) begin
                    nxt_st.rx_state = RX_START;
                // master waits for a tick, so the first bit is full length
                end else if (want_sync && !cur_ff.overrun_error_flag && (tick || !master)) begin
                    nxt_st.rx_state = RX_DATA;
                    nxt_st.bit_cnt  = 4'h0;
                end
            end
            RX_START: begin
                if (decide) begin
                    nxt_st.rx_state = smp_bus.vote ? RX_IDLE : RX_DATA;
                    nxt_st.bit_cnt  = 4'h0;
                end
            end
            RX_DATA: begin
                if (decide) begin
                    // lsb first, bits enter at the top
                    nxt_st.shift   = {smp_bus.vote, cur_ff.shift[8:1]};
                    nxt_st.bit_cnt = cur_ff.bit_cnt + 4'h1;
                    if (cur_ff.bit_cnt == nbits - 4'h1) begin
                        if (sync_m) begin
                            rx_done         = 1'b1;
                            nxt_st.rx_state = RX_IDLE;
                        end else begin
                            nxt_st.rx_state = RX_STOP;
                        end
                    end
                end
            end
            RX_STOP: begin
                if (decide) begin
                    rx_framing_error_flag         = ~smp_bus.vote;
                    rx_done         = 1'b1;
                    nxt_st.rx_state = RX_IDLE;
                end
            end
            default: begin
                nxt_st.rx_state = RX_IDLE;
            end
        endcase

        if (cur_ff.rx_state != RX_IDLE) begin
            if (!cur_ff.serial_port_on || (sync_m ? !want_sync : !cur_ff.continuous_rx_enable)) begin
                nxt_st.rx_state = RX_IDLE;
                rx_done         = 1'b0;
            end
        end

        // master drives the bit clock, idle low
        nxt_st.clk_oe  = cur_ff.serial_port_on & master;
        nxt_st.clk_out = master && (nxt_st.rx_state == RX_DATA) && (nxt_st.phase < (per >> 1));

        // ----------------------------------------------------------------
        // bus slave: address phase
        // ----------------------------------------------------------------
        nxt_st.ap_valid = rd_take & is_mapped(rd_idx);
        nxt_st.ap_write = hwrite;
        nxt_st.ap_index = rd_idx;
        if (rd_take && !hwrite) begin
            case (rd_idx)
                `IDX_RCS:  nxt_st.hrdata = {24'h000000, rcs_view};
                `IDX_TCS:  nxt_st.hrdata = {24'h000000, cur_ff.tcs};
                `IDX_DIV:  nxt_st.hrdata = {24'h000000, cur_ff.baud_divisor};
                `IDX_RBUF: nxt_st.hrdata = {24'h000000, cur_ff.receive_buffer};
                default:   nxt_st.hrdata = 32'h00000000;
            endcase
            // reading the buffer frees it
            if (rd_idx == `IDX_RBUF) begin
                nxt_st.buf_full = 1'b0;
            end
        end

        // ----------------------------------------------------------------
        // bus slave: data phase writes
        // ----------------------------------------------------------------
        if (cur_ff.ap_valid && cur_ff.ap_write) begin
            case (cur_ff.ap_index)
                `IDX_RCS: begin
                    nxt_st.serial_port_on       = hwdata[`RCS_ON];
                    nxt_st.nine_bit_receive     = hwdata[`RCS_NINE];
                    nxt_st.single_rx_enable     = hwdata[`RCS_SINGLE];
                    nxt_st.continuous_rx_enable = hwdata[`RCS_CONT];
                    if (!hwdata[`RCS_CONT]) begin
                        nxt_st.overrun_error_flag = 1'b0;
                    end
                end
                `IDX_TCS: begin
                    nxt_st.tcs = (hwdata[7:0] & `TCS_WMASK) | `TCS_RESET;
                end
                `IDX_DIV: begin
                    nxt_st.baud_divisor = hwdata[7:0];
                    nxt_st.brg_cnt      = 8'h00;
                    nxt_st.phase        = 7'h00;
                end
                default: begin
                    nxt_st.tcs = cur_ff.tcs;
                end
            endcase
        end

        // ----------------------------------------------------------------
        // word completion; hardware sets win over software clears
        // ----------------------------------------------------------------
        if (rx_done) begin
            if (cur_ff.buf_full) begin
                nxt_st.overrun_error_flag = 1'b1;
            end else begin
                nxt_st.buf_full           = 1'b1;
                nxt_st.framing_error_flag = rx_framing_error_flag;
                // ninth bit kept as data, no parity check
                if (cur_ff.nine_bit_receive) begin
                    nxt_st.receive_buffer     = nxt_st.shift[7:0];
                    nxt_st.received_ninth_bit = nxt_st.shift[8];
                end else begin
                    nxt_st.receive_buffer     = nxt_st.shift[8:1];
                    nxt_st.received_ninth_bit = 1'b0;
                end
            end
            // single receive ends after one word
            if (master && !cur_ff.continuous_rx_enable &&
                !(cur_ff.ap_valid && cur_ff.ap_write && cur_ff.ap_index == `IDX_RCS &&
                  hwdata[`RCS_SINGLE])) begin
                nxt_st.single_rx_enable = 1'b0;
            end
        end

        nxt_st.hreadyout = 1'b1;
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            cur_ff <= '{
                serial_port_on:       1'b0,
                nine_bit_receive:     1'b0,
                single_rx_enable:     1'b0,
                continuous_rx_enable: 1'b0,
                framing_error_flag:   1'b0,
                overrun_error_flag:   1'b0,
                received_ninth_bit:   1'b0,
                tcs:                  `TCS_RESET,
                baud_divisor:         `DIV_RESET,
                brg_cnt:              8'h00,
                phase:                7'h00,
                rx_state:             RX_IDLE,
                bit_cnt:              4'h0,
                shift:                9'h000,
                receive_buffer:       8'h00,
                buf_full:             1'b0,
                ext_clk_prev:         1'b0,
                clk_out:              1'b0,
                clk_oe:               1'b0,
                ap_valid:             1'b0,
                ap_write:             1'b0,
                ap_index:             8'h00,
                hrdata:               32'h00000000,
                hreadyout:            1'b1
            };
        end else begin
            cur_ff <= nxt_st;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // responses are always okay, so hresp is a constant low
    assign hrdata           = cur_ff.hrdata;
    assign hreadyout        = cur_ff.hreadyout;
    assign hresp            = 1'b0;
    assign tx_clock_pin_out = cur_ff.clk_out;
    assign tx_clock_pin_oe  = cur_ff.clk_oe;

endmodule

`default_nettype wire

// ---- test/usart_rx_baud_properties.sv ----
// checker of the baud generator and receive control block at its top ports
// assumes: one clock, bound to the design by the line at the foot
`timescale 1ns/1ps
`default_nettype none
`include "usart_consts.svh"

module usart_rx_baud_properties (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        tx_clock_pin_out,
    input wire logic        tx_clock_pin_oe
);
    // ----------------------------------------
    // shadow of register writes
    // ----------------------------------------
    logic       take, wv, on_ff, mst_ff;
    logic [7:0] wa, div_ff;
    logic [9:0] hi_cnt;

    assign take = hsel && hready && htrans[1];

    always_ff @(posedge clk) begin
        wv     <= take && hwrite && !rst;
        wa     <= haddr[9:2];
        hi_cnt <= tx_clock_pin_out ? hi_cnt + 10'h001 : 10'h000;
        if (rst) begin
            div_ff <= 8'h00;
            on_ff  <= 1'b0;
            mst_ff <= 1'b0;
        end else if (wv && wa == `IDX_DIV) begin
            div_ff <= hwdata[7:0];
        end else if (wv && wa == `IDX_RCS) begin
            on_ff <= hwdata[`RCS_ON];
        end else if (wv && wa == `IDX_TCS) begin
            mst_ff <= hwdata[`TCS_SYNC] && hwdata[`TCS_CLOCK_SOURCE_SELECT];
        end
    end

    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    no_wait_a: assert property (hreadyout)
        else $error("wait state seen");
    resp_okay_a: assert property (!hresp)
        else $error("error response");
    upper_zero_a: assert property (hrdata[31:8] == 24'h0)
        else $error("upper read bits set");
    rdata_hold_a: assert property (!$past(take && !hwrite) |-> $stable(hrdata))
        else $error("read data moved");
    clock_idle_a: assert property (!tx_clock_pin_oe |-> !tx_clock_pin_out)
        else $error("clock toggles undriven");
    high_len_a: assert property ($fell(tx_clock_pin_out) |-> hi_cnt == {1'b0, div_ff, 1'b0} + 10'h002)
        else $error("bit clock high time wrong");
    oe_master_a: assert property (tx_clock_pin_oe |-> (on_ff && mst_ff) || $past(on_ff && mst_ff))
        else $error("clock driven outside master");
    oe_follow_a: assert property (on_ff && mst_ff ##1 on_ff && mst_ff |-> tx_clock_pin_oe)
        else $error("master clock not driven");

    cover property (take && !hwrite);
    cover property ($rose(tx_clock_pin_oe));
    cover property ($fell(tx_clock_pin_out));
endmodule

bind usart_rx_baud usart_rx_baud_properties usart_rx_baud_properties_i (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .tx_clock_pin_out(tx_clock_pin_out), .tx_clock_pin_oe(tx_clock_pin_oe));

`default_nettype wire

// ---- test/serial_peer.sv ----
// remote serial party: async sender, sync slave clock source, sync master responder
// assumes: all timing counted in clk cycles of the device
`timescale 1ns/1ps
`default_nettype none

module serial_peer (
    input  wire logic clk,
    input  wire logic bit_clk,
    output var  logic line,
    output var  logic ext_clk
);
    logic [8:0] word;
    int         left = 0;
    logic       bit_clk_q = 1'b0;

    initial line = 1'b1;
    initial ext_clk = 1'b0;

    // start low, lsb first, stop as asked, line idles high
    task automatic send_async(input logic [8:0] d, input int nb, input int len, input logic stp);
        for (int i = 0; i < nb + 2; i++) begin
            @(posedge clk);
            line <= (i == 0) ? 1'b0 : (i == nb + 1) ? stp : d[i-1];
            repeat (len - 1) @(posedge clk);
        end
        @(posedge clk);
        line <= 1'b1;
    endtask

    // bit set with our rising clock, taken by the device at the fall
    task automatic send_sync(input logic [8:0] d, input int nb, input int half);
        for (int i = 0; i < nb; i++) begin
            @(posedge clk);
            line    <= d[i];
            ext_clk <= 1'b1;
            repeat (half) @(posedge clk);
            ext_clk <= 1'b0;
            repeat (half - 1) @(posedge clk);
        end
        @(posedge clk);
        line <= ~line;
    endtask

    task automatic load(input logic [8:0] d, input int nb);
        word = d;
        left = nb;
    endtask

    // answers a rising device clock a cycle late, so only at divisor 0 does the first sample see the old bit
    always @(posedge clk) begin
        bit_clk_q <= bit_clk;
        if (bit_clk && !bit_clk_q) begin
            line <= left > 0 ? word[0] : ~line;
            word <= word >> 1;
            left <= left - 1;
        end
    end
endmodule

`default_nettype wire

// ---- test/usart_baud_gen_rx_control_bench.sv ----
// self-checking bench of the baud generator and receive control block
// assumes: design, checker and serial peer compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "usart_consts.svh"

module usart_baud_gen_rx_control_bench;
    logic        clk = 1'b0, rst = 1'b1, hsel = 1'b1, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0]  htrans = 2'b00;
    logic [2:0]  hsize = 3'b010;
    logic        hreadyout, hresp, rx_line, ext_clk, ck_wire, ck_out, ck_oe;
    logic        clk_q = 1'b0;
    int          n_fail = 0, tests_run = 0, n_rise = 0;

    // the shared clock pin: device drives it as master, the peer otherwise
    assign ck_wire = ck_oe ? ck_out : ext_clk;

    usart_rx_baud usart_rx_baud_i (
        .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .rx_data_pin(rx_line),
        .tx_clock_pin_in(ck_wire), .tx_clock_pin_out(ck_out), .tx_clock_pin_oe(ck_oe));

    serial_peer peer_i (.clk(clk), .bit_clk(ck_out), .line(rx_line), .ext_clk(ext_clk));

    always #20 clk = ~clk;

    always @(posedge clk) begin
        clk_q <= ck_out;
        if (ck_out && !clk_q) n_rise <= n_rise + 1;
    end

    // ----------------------------------------
    // bus and compare helpers
    // ----------------------------------------
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
                       output logic [31:0] q);
        htrans <= 2'b10;
        hwrite <= w;
        haddr  <= {22'h0, idx, 2'b00};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        q = hrdata;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, idx, d, q);
    endtask

    task automatic rdc(input string nm, input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, idx, 8'h00, q);
        chk(nm, exp, q);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs;
        rdc("rcs reset", `IDX_RCS, 32'h00);
        rdc("tcs reset", `IDX_TCS, 32'h02);
        rdc("div reset", `IDX_DIV, 32'h00);
        wr(`IDX_RCS, 8'h4f);
        rdc("rcs ro bits", `IDX_RCS, 32'h40);
        wr(`IDX_TCS, 8'hff);
        rdc("tcs bits", `IDX_TCS, 32'hf7);
        wr(`IDX_DIV, 8'hff);
        rdc("div max", `IDX_DIV, 32'hff);
        wr(8'h30, 8'hff);
        rdc("unmapped", 8'h30, 32'h00);
    endtask

    // slow count started first; the divisor write restarts the timer, so the frame runs at the new rate
    task automatic t_async(input logic [7:0] tcs, input logic [7:0] rcs, input logic [7:0] dv,
                           input int t, input logic [8:0] d, input logic stp, input logic [7:0] st);
        wr(`IDX_TCS, tcs);
        wr(`IDX_RCS, rcs);
        wr(`IDX_DIV, 8'hff);
        repeat (100) @(posedge clk);
        wr(`IDX_DIV, dv);
        peer_i.send_async(d, rcs[6] ? 9 : 8, (dv + 1) * t, stp);
        repeat (4) @(posedge clk);
        rdc("async status", `IDX_RCS, {24'h0, st});
        rdc("async data", `IDX_RBUF, {24'h0, d[7:0]});
    endtask

    task automatic t_overrun;
        wr(`IDX_RCS, 8'h90);
        peer_i.send_async(9'h011, 8, 16, 1'b1);
        peer_i.send_async(9'h022, 8, 16, 1'b1);
        peer_i.send_async(9'h033, 8, 16, 1'b1);
        repeat (4) @(posedge clk);
        rdc("overrun set", `IDX_RCS, 32'h92);
        rdc("first word kept", `IDX_RBUF, 32'h11);
        wr(`IDX_RCS, 8'h82);
        rdc("overrun cleared", `IDX_RCS, 32'h80);
        wr(`IDX_RCS, 8'h90);
        peer_i.send_async(9'h044, 8, 16, 1'b1);
        repeat (4) @(posedge clk);
        rdc("receive resumed", `IDX_RBUF, 32'h44);
    endtask

    task automatic t_master;
        logic [31:0] q;
        wr(`IDX_RCS, 8'h00);
        wr(`IDX_DIV, 8'h03);
        wr(`IDX_TCS, 8'h94);
        peer_i.load(9'h0c3, 8);
        wr(`IDX_RCS, 8'ha0);
        q = 32'h20;
        for (int i = 0; i < 100 && q[5] !== 1'b0; i++) bus(1'b0, `IDX_RCS, 8'h00, q);
        chk("single cleared", 32'h80, q);
        chk("clock count", 32'd8, n_rise);
        chk("master drives clock", 32'h1, {31'h0, ck_oe});
        rdc("master data", `IDX_RBUF, 32'hc3);
        wr(`IDX_RCS, 8'h00);
    endtask

    task automatic t_slave;
        wr(`IDX_TCS, 8'h10);
        wr(`IDX_RCS, 8'h90);
        peer_i.send_sync(9'h06a, 8, 6);
        repeat (4) @(posedge clk);
        rdc("slave data", `IDX_RBUF, 32'h6a);
        chk("slave leaves clock", 32'h0, {31'h0, ck_oe});
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ----------------------------------------
    // sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        t_regs();
        t_async(8'h00, 8'h90, 8'h01, 64, 9'h05a, 1'b1, 8'h90);
        t_async(8'h04, 8'hd0, 8'h02, 16, 9'h1a5, 1'b0, 8'hd5);
        t_async(8'h04, 8'hd0, 8'h00, 16, 9'h03c, 1'b1, 8'hd0);
        t_overrun();
        t_master();
        t_slave();
        give_verdict();
    end

    // whole run is near 3300 cycles; this is a generous ceiling
    initial begin
        repeat (40000) @(posedge clk);
        n_fail++;
        give_verdict();
    end
endmodule

`default_nettype wire
